/* imtw_irq_map.sv */
/*
 File: interrupt line map, priority pick, non-maskable route, tick clock
 select and wake-up detector.
 Every output leaves a flip-flop, so the core sees each line but the pin
 lines, the winner and the divided tick one cycle after the inputs that cause them.
 Assumes: request sources are level sources on core_clk, except pins and
 the reference tick, which come from outside and are synchronised here.
 Sources keep their request high until software clears them at the source;
 this block keeps no pending state of its own.
 A low ce freezes every register, including the debounce counters.
*/
`timescale 1ns/1ps
`include "imtw_consts.svh"
module imtw_irq_map #(
   parameter int WAKE_CYCLES = `IMTW_WAKE_CYCLES,
   parameter int DIAG_W = `IMTW_DIAG_W
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Link-layer sources
   input wire logic link_deep_sleep_wake_irq,
   input wire logic fine_target_timer_irq,
   input wire logic gross_target_timer_irq,
   input wire logic base_tick_irq,
   input wire logic link_active,
   input wire logic link_sleep_end_irq,
   input wire logic link_error_irq,
   input wire logic packet_received_irq,
   input wire logic radio_event_end_irq,
   input wire logic cipher_done_irq,
   input wire logic [DIAG_W-1:0] diag_events,
   input wire logic [DIAG_W-1:0] diagnostic_select_register,
   // Peripheral sources
   input wire logic software_timer_irq,
   input wire logic wake_capture_irq,
   input wire logic pin_combined_irq,
   input wire logic quad_decoder_irq,
   input wire logic first_serial_port_irq,
   input wire logic second_serial_port_irq,
   input wire logic two_wire_irq,
   input wire logic serial_peripheral_irq,
   input wire logic analog_converter_irq,
   input wire logic keypad_scanner_irq,
   input wire logic rf_calibration_irq,
   input wire logic [`IMTW_NUM_PINS-1:0] pin_request,
   input wire logic watchdog_irq,
   // Priority programming
   // One byte per line, written one line at a time by a single strobe.
   // An index of 24 or more is dropped without effect.
   input wire logic prio_we,
   input wire imtw_pkg::imtw_idx_t prio_idx,
   input wire imtw_pkg::imtw_prio_t prio_wdata,
   // Tick clock
   input wire logic tick_clock_select_we,
   input wire logic tick_clock_select_wdata,
   input wire logic reference_tick_1mhz,
   input wire logic [`IMTW_DIV_W-1:0] core_clk_div,
   // Sleep control
   input wire logic deep_sleep_bit,
   input wire logic core_sleeping,
   // Outputs
   // All registered; the winner fields are only meaningful with irq_valid.
   // The tick enable is a single-cycle pulse, the others are levels.
   output imtw_pkg::imtw_lines_t irq_lines,
   output logic nmi,
   output logic irq_valid,
   output imtw_pkg::imtw_idx_t irq_winner,
   output imtw_pkg::imtw_prio_t irq_winner_prio,
   output logic tick_clock_select,
   output logic tick_enable,
   output logic core_power_down,
   output logic core_wake_req
);
   import imtw_pkg::*;

   // ==========================================================
   // Parameter check
   // The restore counter is eight bits wide, so longer restores cannot be
   // counted; a zero length would wrap the end count to 255 and restore for 256 cycles.
   initial begin
      if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255 || DIAG_W < 1)
         $error("imtw_irq_map: unsupported parameters");
   end

   // ==========================================================
   // Pin and reference tick synchronisers
   logic [`IMTW_NUM_PINS-1:0] pin_s1_ff; // First stage, read only by stage two
   logic [`IMTW_NUM_PINS-1:0] pin_s2_ff; // Safe pin levels
   logic ref_s1_ff; // First stage of reference tick
   logic ref_s2_ff; // Synchronised reference tick
   logic ref_s3_ff; // Delayed copy for edge detect

   // Pins and the reference tick change with no relation to core_clk.
   // Only the second and later stages are read by logic, which keeps a metastable
   // first stage away from the debounce and the edge detector.
   // Two flops on every asynchronous input
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         ref_s1_ff <= 1'b0;
         ref_s2_ff <= 1'b0;
         ref_s3_ff <= 1'b0;
      end else if (ce) begin
         pin_s1_ff <= pin_request;
         pin_s2_ff <= pin_s1_ff;
         ref_s1_ff <= reference_tick_1mhz;
         ref_s2_ff <= ref_s1_ff;
         ref_s3_ff <= ref_s2_ff;
      end
   end

   // ==========================================================
   // Debounce stage for the pin lines
   // A pin level must stay put for several cycles before it reaches the
   // line map; short spikes on a pin never make a request.
   // Cost: a genuine pin request arrives a few cycles late.
   imtw_pin_if pin_bus ();
   assign pin_bus.raw = pin_s2_ff;

   imtw_debounce #(
      .N(`IMTW_NUM_PINS),
      .CYCLES(`IMTW_DEB_CYCLES)
   ) u_deb (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .pins(pin_bus)
   );

   // ==========================================================
   // Line map; each line is the source level itself
   // The line number doubles as the inherent priority, so the map below
   // fixes which request wins a tie.
   // The base tick line is gated by link activity, the diagnostic line by
   // a select mask, and line 9 merges three peripheral requests.
   imtw_lines_t nxt_lines;
   wire tick_gated = base_tick_irq & link_active;
   wire wcd_any = wake_capture_irq | pin_combined_irq | quad_decoder_irq;
   wire diag_any = |(diag_events & diagnostic_select_register);

   always_comb begin
      nxt_lines = '0;
      nxt_lines[`IMTW_LINE_WAKE] = link_deep_sleep_wake_irq;
      nxt_lines[`IMTW_LINE_FINE] = fine_target_timer_irq;
      nxt_lines[`IMTW_LINE_GROSS] = gross_target_timer_irq;
      nxt_lines[`IMTW_LINE_TICK] = tick_gated;
      nxt_lines[`IMTW_LINE_SLEEP_END] = link_sleep_end_irq;
      nxt_lines[`IMTW_LINE_ERROR] = link_error_irq;
      nxt_lines[`IMTW_LINE_RX] = packet_received_irq;
      nxt_lines[`IMTW_LINE_EVENT] = radio_event_end_irq;
      nxt_lines[`IMTW_LINE_SWTIM] = software_timer_irq;
      nxt_lines[`IMTW_LINE_WCD] = wcd_any;
      nxt_lines[`IMTW_LINE_DIAG] = diag_any;
      nxt_lines[`IMTW_LINE_CIPHER] = cipher_done_irq;
      nxt_lines[`IMTW_LINE_SER1] = first_serial_port_irq;
      nxt_lines[`IMTW_LINE_SER2] = second_serial_port_irq;
      nxt_lines[`IMTW_LINE_TWO_WIRE] = two_wire_irq;
      nxt_lines[`IMTW_LINE_SPI] = serial_peripheral_irq;
      nxt_lines[`IMTW_LINE_ADC] = analog_converter_irq;
      nxt_lines[`IMTW_LINE_KEYPAD] = keypad_scanner_irq;
      nxt_lines[`IMTW_LINE_RFCAL] = rf_calibration_irq;
      nxt_lines[`IMTW_LINE_PIN0 +: `IMTW_NUM_PINS] = pin_bus.clean;
   end

   // ==========================================================
   // Priority table, one byte per line
   imtw_prio_t prio_ff [`IMTW_NUM_LINES]; // Programmed priorities

   // Software writes one byte at a time; out-of-range index ignored
   // All entries restart at zero, so until software programs them every
   // line has equal priority and the line number alone decides.
   // A new value takes effect on the pick one cycle after the write.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `IMTW_NUM_LINES; i++)
            prio_ff[i] <= `IMTW_PRIO_RST;
      end else if (ce && prio_we && prio_idx < 5'(`IMTW_NUM_LINES)) begin
         prio_ff[prio_idx] <= prio_wdata;
      end
   end

   // ==========================================================
   // Pick most urgent pending line
   // Scanning upward with strict less-than keeps the lowest number on
   // a tie; a linear scan is slow but 24 entries fit a 10 ns cycle.
   // With nothing pending the winner fields read as zero.
   logic nxt_valid;
   imtw_idx_t nxt_winner;
   imtw_prio_t nxt_wprio;

   always_comb begin
      nxt_valid = 1'b0;
      nxt_winner = '0;
      nxt_wprio = '1;
      for (int i = 0; i < `IMTW_NUM_LINES; i++) begin
         // Lower value more urgent ties to lower line
         if (nxt_lines[i] && (!nxt_valid || prio_ff[i] < nxt_wprio)) begin
            nxt_valid = 1'b1;
            nxt_winner = 5'(i);
            nxt_wprio = prio_ff[i];
         end
      end
   end

   // ==========================================================
   // Tick clock select and tick enable
   // The reference source gives one pulse per rising edge of the
   // synchronised reference; the divided source gives one pulse every
   // 2, 4, 8 or 16 core cycles. Software owns the choice of divider, and
   // must allow for it when it turns tick counts into time.
   logic [3:0] div_cnt_ff; // Divided core clock counter
   logic tcs_ff; // Tick clock select
   wire ref_edge = ref_s2_ff & ~ref_s3_ff;
   // Widened before the add, so the largest divider does not wrap to zero
   wire [3:0] div_max = 4'((1 << (3'(core_clk_div) + 3'd1)) - 1);
   wire div_edge = div_cnt_ff == div_max;
   imtw_wake_t wake_ff; // Wake detector state
   wire core_off = wake_ff != IMTW_AWAKE;
   // Timer halts while core is powered down
   wire nxt_tick = core_off ? 1'b0 : (tcs_ff ? div_edge : ref_edge);

   // Select register and divider counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tcs_ff <= `IMTW_TCS_RST;
         div_cnt_ff <= 4'h0;
      end else if (ce) begin
         if (tick_clock_select_we)
            tcs_ff <= tick_clock_select_wdata;
         div_cnt_ff <= div_edge ? 4'h0 : div_cnt_ff + 4'h1;
      end
   end

   // ==========================================================
   // Wake-up detector: hardware only, no registers visible
   // It arms only when the core sleeps with deep sleep chosen and nothing
   // is pending; arming with a request already up would power the core
   // down and wake it again at once.
   // Any line or the watchdog ends the sleep. The restore time is fixed by
   // WAKE_CYCLES, and delivery of the winner waits until it has passed.
   logic [7:0] wcnt_ff; // Wake restore counter, counts up from zero
   imtw_wake_t nxt_wake;
   wire any_req = (|nxt_lines) | watchdog_irq;

   always_comb begin
      nxt_wake = wake_ff;
      case (wake_ff)
         IMTW_AWAKE: begin
            // Only armed with deep sleep set
            if (deep_sleep_bit && core_sleeping && !any_req)
               nxt_wake = IMTW_ARMED;
         end
         IMTW_ARMED: begin
            if (any_req)
               nxt_wake = IMTW_WAKING;
         end
         IMTW_WAKING: begin
            // Restore takes WAKE_CYCLES before delivery
            if (wcnt_ff == 8'(WAKE_CYCLES - 1))
               nxt_wake = IMTW_AWAKE;
         end
         default: nxt_wake = IMTW_AWAKE;
      endcase
   end

   // State and restore counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wake_ff <= IMTW_AWAKE;
         wcnt_ff <= 8'h00;
      end else if (ce) begin
         wake_ff <= nxt_wake;
         wcnt_ff <= (wake_ff == IMTW_WAKING) ? wcnt_ff + 8'h01 : 8'h00;
      end
   end

   // ==========================================================
   // Registered outputs
   // Power state outputs are taken from the next state, so the power
   // manager sees a change in the same cycle as the detector's own state.
   // The tick is gated on the next state too: no pulse may appear in the
   // cycle in which the core is reported powered down.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_lines <= '0;
         nmi <= 1'b0;
         irq_valid <= 1'b0;
         irq_winner <= '0;
         irq_winner_prio <= '0;
         tick_clock_select <= `IMTW_TCS_RST;
         tick_enable <= 1'b0;
         core_power_down <= 1'b0;
         core_wake_req <= 1'b0;
      end else if (ce) begin
         irq_lines <= nxt_lines;
         nmi <= watchdog_irq;
         // Delivery held back until core restored
         irq_valid <= nxt_valid & ~core_off;
         irq_winner <= nxt_winner;
         irq_winner_prio <= nxt_valid ? nxt_wprio : '0;
         tick_clock_select <= tcs_ff;
         tick_enable <= nxt_tick & (nxt_wake == IMTW_AWAKE);
         core_power_down <= nxt_wake == IMTW_ARMED;
         core_wake_req <= nxt_wake == IMTW_WAKING;
      end
   end
endmodule : imtw_irq_map

/* imtw_consts.svh */
/*
 File: constants for the interrupt mapping, tick clock select and wake detector.
 Assumes: included by bare name from the package and design modules.
*/
`ifndef IMTW_CONSTS_SVH
`define IMTW_CONSTS_SVH

// ==========================================================
// Line map
`define IMTW_NUM_LINES 24
`define IMTW_LINE_WAKE 0
`define IMTW_LINE_FINE 1
`define IMTW_LINE_GROSS 2
`define IMTW_LINE_TICK 3
`define IMTW_LINE_SLEEP_END 4
`define IMTW_LINE_ERROR 5
`define IMTW_LINE_RX 6
`define IMTW_LINE_EVENT 7
`define IMTW_LINE_SWTIM 8
`define IMTW_LINE_WCD 9
`define IMTW_LINE_DIAG 10
`define IMTW_LINE_CIPHER 11
`define IMTW_LINE_SER1 12
`define IMTW_LINE_SER2 13
`define IMTW_LINE_TWO_WIRE 14
`define IMTW_LINE_SPI 15
`define IMTW_LINE_ADC 16
`define IMTW_LINE_KEYPAD 17
`define IMTW_LINE_RFCAL 18
`define IMTW_LINE_PIN0 19
`define IMTW_NUM_PINS 5

// ==========================================================
// Fields, reset values, timing
`define IMTW_PRIO_W 8
`define IMTW_PRIO_RST 8'h0
`define IMTW_TCS_RST 1'b0
`define IMTW_DIAG_W 8
`define IMTW_DEB_CYCLES 4
`define IMTW_WAKE_CYCLES 8
`define IMTW_DIV_W 2

`endif

/* imtw_pkg.sv */
/*
 File: types shared by the interrupt mapping block.
 Assumes: imtw_consts.svh is on the include path.
*/
`include "imtw_consts.svh"
package imtw_pkg;
   // Request vector and priority word
   typedef logic [`IMTW_NUM_LINES-1:0] imtw_lines_t;
   typedef logic [`IMTW_PRIO_W-1:0] imtw_prio_t;
   typedef logic [4:0] imtw_idx_t;
   // Wake detector states
   typedef enum logic [1:0] {
      IMTW_AWAKE,
      IMTW_ARMED,
      IMTW_WAKING
   } imtw_wake_t;
endpackage : imtw_pkg

/* imtw_pin_if.sv */
/*
 File: carrier between the top and the pin debounce module.
 Assumes: both ends run on core_clk.
*/
`timescale 1ns/1ps
`include "imtw_consts.svh"
interface imtw_pin_if;
   logic [`IMTW_NUM_PINS-1:0] raw; // Synchronised pin requests
   logic [`IMTW_NUM_PINS-1:0] clean; // Debounced requests
   modport top (output raw, input clean);
   modport deb (input raw, output clean);
endinterface : imtw_pin_if

/* imtw_debounce.sv */
/*
 File: debounce stage for the five pin request lines.
 Assumes: inputs are already synchronised to core_clk.
*/
`timescale 1ns/1ps
`include "imtw_consts.svh"
module imtw_debounce #(
   parameter int N = `IMTW_NUM_PINS,
   parameter int CYCLES = `IMTW_DEB_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   imtw_pin_if.deb pins
);
   import imtw_pkg::*;

   // ==========================================================
   // Parameter check
   initial begin
      if (CYCLES < 1 || CYCLES > 255 || N != `IMTW_NUM_PINS)
         $error("imtw_debounce: unsupported parameters");
   end

   logic [7:0] cnt_ff [N]; // Stability counters
   logic [N-1:0] out_ff; // Accepted levels

   // ==========================================================
   // Accept a level only after it stays for CYCLES cycles
   for (genvar i = 0; i < N; i++) begin : g_pin
      wire differs = pins.raw[i] != out_ff[i];
      wire done = cnt_ff[i] == 8'(CYCLES - 1);
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            cnt_ff[i] <= 8'h00;
            out_ff[i] <= 1'b0;
         end else if (ce) begin
            // Any glitch restarts the count
            if (!differs) begin
               cnt_ff[i] <= 8'h00;
            end else if (done) begin
               cnt_ff[i] <= 8'h00;
               out_ff[i] <= pins.raw[i];
            end else begin
               cnt_ff[i] <= cnt_ff[i] + 8'h01;
            end
         end
      end
   end
   assign pins.clean = out_ff;
endmodule : imtw_debounce

/* imtw_irq_map_properties.sv */
/*
 Concurrent checks on the ports of the interrupt mapping block.
 Assumes default WAKE_CYCLES of 8 and a single core_clk domain.
*/
`timescale 1ns/1ps
// ==========
// Port checker
module imtw_props #(
   parameter int DIAG_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic packet_received_irq,
   input wire logic base_tick_irq,
   input wire logic link_active,
   input wire logic wake_capture_irq,
   input wire logic pin_combined_irq,
   input wire logic quad_decoder_irq,
   input wire logic [DIAG_W-1:0] diag_events,
   input wire logic [DIAG_W-1:0] diagnostic_select_register,
   input wire logic watchdog_irq,
   input wire logic deep_sleep_bit,
   input wire imtw_pkg::imtw_lines_t irq_lines,
   input wire logic nmi,
   input wire logic irq_valid,
   input wire imtw_pkg::imtw_idx_t irq_winner,
   input wire logic tick_clock_select,
   input wire logic tick_enable,
   input wire logic core_power_down,
   input wire logic core_wake_req
);
   import imtw_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic live_ff; // Previous cycle ran out of reset
   // Guards one-cycle relations against reset and frozen cycles
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         live_ff <= 1'b0;
      end else begin
         live_ff <= ce;
      end
   end
   property p_nmi;
      live_ff |-> nmi == $past(watchdog_irq);
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi does not follow watchdog");
   property p_rx;
      live_ff |-> irq_lines[6] == $past(packet_received_irq);
   endproperty
   a_rx: assert property (p_rx) else $error("line 6 wrong");
   property p_base;
      live_ff |-> irq_lines[3] == $past(base_tick_irq && link_active);
   endproperty
   a_base: assert property (p_base) else $error("line 3 wrong");
   property p_comb;
      live_ff |-> irq_lines[9] == $past(wake_capture_irq | pin_combined_irq | quad_decoder_irq);
   endproperty
   a_comb: assert property (p_comb) else $error("line 9 wrong");
   property p_diag;
      live_ff |-> irq_lines[10] == $past(|(diag_events & diagnostic_select_register));
   endproperty
   a_diag: assert property (p_diag) else $error("line 10 wrong");
   property p_sel_rst;
      $past(rst) |-> !tick_clock_select;
   endproperty
   a_sel_rst: assert property (p_sel_rst) else $error("select not cleared");
   property p_wake_len;
      $rose(core_wake_req) |-> core_wake_req[*8] ##1 !core_wake_req;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake length wrong");
   property p_wake_hold;
      (core_wake_req || core_power_down) |-> !irq_valid;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("valid during sleep");
   property p_arm;
      $rose(core_power_down) |-> $past(deep_sleep_bit);
   endproperty
   a_arm: assert property (p_arm) else $error("armed outside deep sleep");
   property p_halt;
      core_power_down |-> !tick_enable;
   endproperty
   a_halt: assert property (p_halt) else $error("tick runs while down");
   property p_win;
      irq_valid |-> irq_lines[irq_winner];
   endproperty
   a_win: assert property (p_win) else $error("winner not pending");
endmodule : imtw_props

bind imtw_irq_map imtw_props #(.DIAG_W(DIAG_W)) chk_u (.core_clk, .rst, .ce,
   .packet_received_irq, .base_tick_irq, .link_active, .wake_capture_irq,
   .pin_combined_irq, .quad_decoder_irq, .diag_events, .diagnostic_select_register,
   .watchdog_irq, .deep_sleep_bit, .irq_lines, .nmi, .irq_valid, .irq_winner,
   .tick_clock_select, .tick_enable, .core_power_down, .core_wake_req);

/* imtw_src_model.sv */
/*
 Request source bank: each line is pending from set until cleared.
 Assumes set and clear pulses come from the bench on core_clk.
*/
`timescale 1ns/1ps
// ==========
// Source model
module imtw_src_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire imtw_pkg::imtw_lines_t set_v,
   input wire imtw_pkg::imtw_lines_t clr_v,
   output imtw_pkg::imtw_lines_t pend
);
   import imtw_pkg::*;
   imtw_lines_t pend_ff; // Pending flags
   // Held until software clears, clear wins over set
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= (pend_ff | set_v) & ~clr_v;
      end
   end
   assign pend = pend_ff;
endmodule : imtw_src_model

/* test_irq_map_tick_and_wakeup.sv */
/*
 Bench for the interrupt mapping block: line map, priority, nmi, tick, wake.
 Assumes inputs change at the falling edge and outputs are read there.
*/
`timescale 1ns/1ps
module test_irq_map_tick_and_wakeup;
   import imtw_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, link_active = 1'b1, wdog = 1'b0;
   logic deep = 1'b0, sleeping = 1'b0, sel_we = 1'b0, sel_d = 1'b0, ref_tick = 1'b0;
   logic prio_we = 1'b0;
   logic [1:0] l9 = 2'h0, div = 2'h0;
   logic [7:0] dsel = 8'hFF;
   imtw_idx_t prio_idx = 5'h00;
   imtw_prio_t prio_d = 8'h00, win_prio;
   imtw_lines_t set_v = '0, clr_v = '0, pend, irq_lines;
   imtw_idx_t win;
   logic nmi, valid, tsel, ten, down, wreq;
   int miscompares = 0, compares = 0, n, c;
   always #5 core_clk = ~core_clk;
   imtw_src_model src_u (.core_clk, .rst, .set_v, .clr_v, .pend);
   imtw_irq_map dut_u (.core_clk, .rst, .ce, .link_deep_sleep_wake_irq(pend[0]),
      .fine_target_timer_irq(pend[1]), .gross_target_timer_irq(pend[2]),
      .base_tick_irq(pend[3]), .link_active, .link_sleep_end_irq(pend[4]),
      .link_error_irq(pend[5]), .packet_received_irq(pend[6]),
      .radio_event_end_irq(pend[7]), .cipher_done_irq(pend[11]),
      .diag_events({8{pend[10]}}), .diagnostic_select_register(dsel),
      .software_timer_irq(pend[8]), .wake_capture_irq(pend[9]), .pin_combined_irq(l9[0]),
      .quad_decoder_irq(l9[1]), .first_serial_port_irq(pend[12]),
      .second_serial_port_irq(pend[13]), .two_wire_irq(pend[14]),
      .serial_peripheral_irq(pend[15]), .analog_converter_irq(pend[16]),
      .keypad_scanner_irq(pend[17]), .rf_calibration_irq(pend[18]),
      .pin_request(pend[23:19]), .watchdog_irq(wdog), .prio_we, .prio_idx,
      .prio_wdata(prio_d), .tick_clock_select_we(sel_we), .tick_clock_select_wdata(sel_d),
      .reference_tick_1mhz(ref_tick), .core_clk_div(div), .deep_sleep_bit(deep),
      .core_sleeping(sleeping), .irq_lines, .nmi, .irq_valid(valid), .irq_winner(win),
      .irq_winner_prio(win_prio), .tick_clock_select(tsel), .tick_enable(ten),
      .core_power_down(down), .core_wake_req(wreq));
   // ==========
   // Shared tasks
   task tick(input int k);
      repeat (k) @(negedge core_clk);
   endtask : tick
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // Pulse set or clear for one cycle; pins need time to debounce
   task raise(input int l);
      set_v = 24'h1 << l;
      tick(1);
      set_v = '0;
      tick(l >= 19 ? 10 : 2);
   endtask : raise
   task drop(input int l);
      clr_v = 24'h1 << l;
      tick(1);
      clr_v = '0;
      tick(l >= 19 ? 10 : 2);
   endtask : drop
   task set_prio(input int l, input logic [7:0] v);
      prio_we = 1'b1;
      prio_idx = 5'(l);
      prio_d = v;
      tick(1);
      prio_we = 1'b0;
      tick(1);
   endtask : set_prio
   // Counts tick pulses; with use_ref the 1 MHz reference toggles every 4 cycles
   task count_ticks(input int k, input logic use_ref, output int cnt);
      cnt = 0;
      for (int i = 0; i < k; i++) begin
         ref_tick = use_ref && ((i % 8) < 4);
         tick(1);
         cnt += int'(ten === 1'b1);
      end
   endtask : count_ticks
   // ==========
   // Scenarios
   initial begin
      tick(2);
      rst = 1'b0;
      tick(2);
      check(irq_lines, 32'h0);
      check(win_prio, 32'h0);
      check(tsel, 32'h0);
      for (int l = 0; l < 24; l++) begin
         raise(l);
         check(irq_lines, 32'h1 << l);
         check(win, l);
         drop(l);
         check(irq_lines, 32'h0);
      end
      ce = 1'b0;
      raise(5);
      check(irq_lines, 32'h0);
      ce = 1'b1;
      tick(2);
      check(irq_lines, 32'h20);
      drop(5);
      link_active = 1'b0;
      dsel = 8'h00;
      raise(3);
      raise(10);
      check(irq_lines, 32'h0);
      drop(3);
      drop(10);
      l9 = 2'h1;
      tick(2);
      check(irq_lines, 32'h200);
      l9 = 2'h2;
      tick(2);
      check(irq_lines, 32'h200);
      l9 = 2'h0;
      raise(6);
      raise(12);
      check(win, 32'h6);
      set_prio(6, 8'h05);
      set_prio(12, 8'h02);
      set_prio(24, 8'h00);
      tick(2);
      check({win_prio, 3'h0, win}, 32'h20C);
      drop(12);
      check({win_prio, 3'h0, win}, 32'h506);
      drop(6);
      wdog = 1'b1;
      tick(2);
      check({nmi, irq_lines}, 32'h1000000);
      wdog = 1'b0;
      sel_we = 1'b1;
      sel_d = 1'b1;
      tick(1);
      sel_we = 1'b0;
      tick(1);
      check(tsel, 32'h1);
      count_ticks(16, 1'b0, c);
      check(c, 32'h8);
      div = 2'h3;
      count_ticks(32, 1'b0, c);
      check(c, 32'h2);
      sel_d = 1'b0;
      sel_we = 1'b1;
      tick(1);
      sel_we = 1'b0;
      count_ticks(40, 1'b1, c);
      check(c, 32'h5);
      sleeping = 1'b1;
      tick(3);
      check(down, 32'h0);
      deep = 1'b1;
      tick(3);
      check({down, ten}, 32'h2);
      set_v = 24'h40;
      tick(1);
      set_v = '0;
      tick(1);
      check({wreq, valid}, 32'h2);
      n = 0;
      while (valid !== 1'b1 && n < 30) begin
         tick(1);
         n++;
      end
      if (n == 30) begin
         miscompares++;
      end else begin
         check(n >= 6, 32'h1);
      end
      complete_run;
   end
endmodule : test_irq_map_tick_and_wakeup
